// ### logic/mlk_pkg.sv
`default_nettype none
package mlk_pkg;

  // Widths and sizes
  localparam int          DATA_W    = 16;
  localparam int          ADDR_W    = 8;
  localparam int          NUM_ST    = 8;
  localparam int          SLOTS     = 12;
  localparam logic [3:0]  BIT_SLOT  = 4'h8;

  // Register offsets
  localparam logic [7:0]  ADDR_STATION   = 8'h00;
  localparam logic [7:0]  ADDR_SLAVE_QTY = 8'h01;
  localparam logic [7:0]  ADDR_PATTERN   = 8'h02;
  localparam logic [7:0]  ADDR_RETRY     = 8'h03;
  localparam logic [7:0]  ADDR_MONITOR   = 8'h04;
  localparam logic [7:0]  ADDR_STATUS    = 8'h05;
  localparam logic [7:0]  ADDR_IRQ_STAT  = 8'h06;
  localparam logic [7:0]  ADDR_IRQ_MASK  = 8'h07;
  localparam logic [7:0]  WORD_AREA      = 8'h40;
  localparam logic [7:0]  WORD_SPAN      = 8'h50;
  localparam logic [7:0]  WORD_STRIDE    = 8'h0A;
  localparam logic [7:0]  BIT_AREA       = 8'hC0;
  localparam logic [7:0]  BIT_SPAN       = 8'h20;
  localparam logic [7:0]  BIT_GROUPS     = 8'h04;

  // Reset values and limits
  localparam logic [15:0] STATION_RST    = 16'h0000;
  localparam logic [15:0] STATION_MAX    = 16'h0007;
  localparam logic [15:0] SLAVE_QTY_RST  = 16'h0007;
  localparam logic [15:0] SLAVE_QTY_MIN  = 16'h0001;
  localparam logic [15:0] SLAVE_QTY_MAX  = 16'h0007;
  localparam logic [15:0] PATTERN_RST    = 16'h0000;
  localparam logic [15:0] PATTERN_MAX    = 16'h0002;
  localparam logic [15:0] RETRY_RST      = 16'h0003;
  localparam logic [15:0] RETRY_MAX      = 16'h000A;
  localparam logic [15:0] MONITOR_RST    = 16'h0005;
  localparam logic [15:0] MONITOR_MIN    = 16'h0005;
  localparam logic [15:0] MONITOR_MAX    = 16'h00FF;
  localparam logic [7:0]  SLAVE_WATCH    = 8'hFF;

  // Area sizes per pattern, in 16-bit slots
  localparam logic [3:0]  WORDS_P01      = 4'h4;
  localparam logic [3:0]  WORDS_P2       = 4'h8;
  localparam logic [3:0]  BITS_P1        = 4'h2;
  localparam logic [3:0]  BITS_P2        = 4'h4;

  // Monitoring time unit
  localparam int          MON_UNIT_MS     = 10;
  localparam int          CLK_PERIOD_NS   = 100;
  localparam int          MON_UNIT_CYCLES = MON_UNIT_MS * 1000000 / CLK_PERIOD_NS;

  typedef enum logic {FRAME_POLL, FRAME_DATA} mlk_kind_type;

  typedef struct packed {
    mlk_kind_type kind;
    logic [2:0]   station;
    logic [3:0]   index;
    logic [15:0]  data;
  } mlk_frame_type;

  typedef struct packed {
    logic       ok;
    logic [2:0] station;
    logic [3:0] index;
  } mlk_slot_type;

  typedef enum logic [1:0] {ST_IDLE, ST_SEND, ST_POLL, ST_WAIT} mlk_state_type;

endpackage
`default_nettype wire

// ### logic/mlk_station.sv
// Summary of operation
// - Station number 0 makes a master, 1 to 7 a slave; resets to 0.
// - Master polls only slave quantity slaves, range 1 to 7, default 7.
// - Master takes refresh pattern 0, 1 or 2; resets to 0.
// - Unanswered poll is retried up to retry count (0..10, default 3), then error.
// - Response timeout is monitor word times 10 ms, word 5 to 255, default 5.
// - A slave ignores quantity, pattern, retry and monitor words; master's govern.
// - Channel select high routes the link to port 2, else port 1.
// - Master sequence error flag sets on a transfer sequence error at master.
// - One sequence error flag per slave 1 to 7, set on that slave's error.
// - Link running flag stays high while the exchange operates.
// - Pattern 0: 4 words per station at word base ten times station.
// - Pattern 1: 32 bits at 1000 plus 64 times station, plus 4 words.
// - Pattern 2: 64 bits at 1000 plus 64 times station, plus 8 words.
// - On link error shared points hold their last values, never cleared.
`timescale 1ns/10ps
`default_nettype none
module mlk_station
  import mlk_pkg::*;
#(
  parameter int unsigned UNIT_CYCLES = MON_UNIT_CYCLES
)
(
  // Clock and reset
  input  wire logic                CLK_SYS_I,
  input  wire logic                RESETN_I,
  // Register port
  input  wire logic [ADDR_W-1:0]   REG_ADDR_I,
  input  wire logic [DATA_W-1:0]   REG_WDATA_I,
  input  wire logic                REG_WR_I,
  input  wire logic                REG_RD_I,
  output logic      [DATA_W-1:0]   REG_RDATA_O,
  // Configuration pins
  input  wire logic                PARAM_SET_I,
  input  wire logic                CH_SELECT_I,
  output logic                     PORT_SEL_O,
  // Link frames
  input  wire logic                RX_VALID_I,
  input  wire mlk_frame_type       RX_FRAME_I,
  input  wire logic                TX_READY_I,
  output logic                     TX_VALID_O,
  output mlk_frame_type            TX_FRAME_O,
  // Status
  output logic [NUM_ST-1:0]        SEQ_ERR_O,
  output logic                     LINK_RUN_O,
  output logic                     IRQ_O
);

  logic [1:0]          rst_sync;
  logic                rst_n;
  logic                param_meta;
  logic                param_sync;
  logic                ch_meta;
  logic                ch_sync;
  logic                port_sel;
  logic [15:0]         station_number;
  logic [15:0]         slave_quantity;
  logic [15:0]         refresh_pattern;
  logic [15:0]         retry_count;
  logic [15:0]         monitor_time;
  logic [7:0]          irq_stat;
  logic [7:0]          irq_mask;
  logic [15:0]         rdata;
  logic                irq;
  logic [15:0]         next_station_number;
  logic [15:0]         next_slave_quantity;
  logic [15:0]         next_refresh_pattern;
  logic [15:0]         next_retry_count;
  logic [15:0]         next_monitor_time;
  logic [7:0]          next_irq_stat;
  logic [7:0]          next_irq_mask;
  logic [15:0]         next_rdata;
  logic                next_irq;
  mlk_state_type       state;
  mlk_state_type       next_state;
  logic [2:0]          target;
  logic [2:0]          next_target;
  logic [3:0]          item;
  logic [3:0]          next_item;
  logic [3:0]          attempt;
  logic [3:0]          next_attempt;
  logic [7:0]          units;
  logic [7:0]          next_units;
  logic [7:0]          watch;
  logic [7:0]          next_watch;
  logic [19:0]         prescale;
  logic [19:0]         next_prescale;
  logic [1:0]          slave_pat;
  logic [1:0]          next_slave_pat;
  logic [7:0]          seq_err;
  logic [7:0]          next_seq_err;
  logic                running;
  logic                next_running;
  logic                cyc_fault;
  logic                next_cyc_fault;
  logic                tx_valid;
  logic                next_tx_valid;
  mlk_frame_type       tx_frame;
  mlk_frame_type       next_tx_frame;
  logic                tick;
  logic                give_up;
  logic                is_master;
  logic [2:0]          own;
  logic [1:0]          act_pat;
  logic [3:0]          total;
  logic                rx_data;
  logic                mem_rx_we;
  logic                mem_bus_we;
  mlk_slot_type        bus_slot;
  logic [DATA_W-1:0]   shared_mem [NUM_ST][SLOTS];

  function automatic logic [3:0] word_count(input logic [1:0] p);
    word_count = (p == 2'h2) ? WORDS_P2 : WORDS_P01;
  endfunction

  function automatic logic [3:0] bit_count(input logic [1:0] p);
    if (p == 2'h0)
      bit_count = 4'h0;
    else if (p == 2'h1)
      bit_count = BITS_P1;
    else
      bit_count = BITS_P2;
  endfunction

  function automatic logic [3:0] slot_index(input logic [1:0] p, input logic [3:0] j);
    slot_index = (j < word_count(p)) ? j : 4'(BIT_SLOT + j - word_count(p));
  endfunction

  function automatic logic slot_live(input logic [1:0] p, input logic [3:0] idx);
    slot_live = (idx < BIT_SLOT) ? (idx < word_count(p)) : (4'(idx - BIT_SLOT) < bit_count(p));
  endfunction

  // Bus address to shared slot
  function automatic mlk_slot_type map_addr(input logic [ADDR_W-1:0] a, input logic [1:0] p);
    logic [ADDR_W-1:0] off;
    off = '0;
    map_addr = '0;
    if (a >= WORD_AREA && a < 8'(WORD_AREA + WORD_SPAN))
    begin
      off = 8'(a - WORD_AREA);
      map_addr.station = 3'(off / WORD_STRIDE);
      map_addr.index   = 4'(off % WORD_STRIDE);
    end
    else if (a >= BIT_AREA && a < 8'(BIT_AREA + BIT_SPAN))
    begin
      off = 8'(a - BIT_AREA);
      map_addr.station = 3'(off / BIT_GROUPS);
      map_addr.index   = 4'(BIT_SLOT + 4'(off % BIT_GROUPS));
    end
    map_addr.ok = (off != 8'h00 || a == WORD_AREA || a == BIT_AREA)
                  && slot_live(p, map_addr.index);
  endfunction

  function automatic logic cfg_ok(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] v);
    case (a)
      ADDR_STATION:   cfg_ok = v <= STATION_MAX;
      ADDR_SLAVE_QTY: cfg_ok = v >= SLAVE_QTY_MIN && v <= SLAVE_QTY_MAX;
      ADDR_PATTERN:   cfg_ok = v <= PATTERN_MAX;
      ADDR_RETRY:     cfg_ok = v <= RETRY_MAX;
      ADDR_MONITOR:   cfg_ok = v >= MONITOR_MIN && v <= MONITOR_MAX;
      default:        cfg_ok = 1'b0;
    endcase
  endfunction

  // Reset release and pin synchronisers
  always_ff @(posedge CLK_SYS_I or negedge RESETN_I)
  begin
    if (!RESETN_I)
    begin
      rst_sync   <= 2'h0;
      param_meta <= 1'b0;
      param_sync <= 1'b0;
      ch_meta    <= 1'b0;
      ch_sync    <= 1'b0;
    end
    else
    begin
      rst_sync   <= {rst_sync[0], 1'b1};
      param_meta <= PARAM_SET_I;
      param_sync <= param_meta;
      ch_meta    <= CH_SELECT_I;
      ch_sync    <= ch_meta;
    end
  end

  assign rst_n     = rst_sync[1];
  assign is_master = (station_number == STATION_RST);
  assign own       = station_number[2:0];
  assign act_pat   = is_master ? refresh_pattern[1:0] : slave_pat;
  assign total     = 4'(word_count(act_pat) + bit_count(act_pat));
  assign bus_slot  = map_addr(REG_ADDR_I, act_pat);

  // Register file
  always_comb
  begin
    next_station_number  = station_number;
    next_slave_quantity  = slave_quantity;
    next_refresh_pattern = refresh_pattern;
    next_retry_count     = retry_count;
    next_monitor_time    = monitor_time;
    next_irq_mask        = irq_mask;
    next_rdata           = 16'h0000;
    next_irq_stat        = irq_stat;
    if (REG_WR_I && param_sync && cfg_ok(REG_ADDR_I, REG_WDATA_I))
    begin
      unique case (REG_ADDR_I)
        ADDR_STATION:   next_station_number  = REG_WDATA_I;
        ADDR_SLAVE_QTY: next_slave_quantity  = REG_WDATA_I;
        ADDR_PATTERN:   next_refresh_pattern = REG_WDATA_I;
        ADDR_RETRY:     next_retry_count     = REG_WDATA_I;
        default:        next_monitor_time    = REG_WDATA_I;
      endcase
    end
    if (REG_WR_I && REG_ADDR_I == ADDR_IRQ_MASK)
      next_irq_mask = REG_WDATA_I[7:0];
    if (REG_WR_I && REG_ADDR_I == ADDR_IRQ_STAT)
      next_irq_stat = irq_stat & ~REG_WDATA_I[7:0];
    next_irq_stat = next_irq_stat | (next_seq_err & ~seq_err);
    next_irq      = |(next_irq_stat & next_irq_mask);
    if (REG_RD_I)
    begin
      case (REG_ADDR_I)
        ADDR_STATION:   next_rdata = station_number;
        ADDR_SLAVE_QTY: next_rdata = slave_quantity;
        ADDR_PATTERN:   next_rdata = refresh_pattern;
        ADDR_RETRY:     next_rdata = retry_count;
        ADDR_MONITOR:   next_rdata = monitor_time;
        ADDR_STATUS:    next_rdata = {5'h00, port_sel, is_master, running, seq_err};
        ADDR_IRQ_STAT:  next_rdata = {8'h00, irq_stat};
        ADDR_IRQ_MASK:  next_rdata = {8'h00, irq_mask};
        default:
          if (bus_slot.ok)
            next_rdata = shared_mem[bus_slot.station][bus_slot.index];
      endcase
    end
  end

  always_ff @(posedge CLK_SYS_I or negedge rst_n)
  begin
    if (!rst_n)
    begin
      station_number  <= STATION_RST;
      slave_quantity  <= SLAVE_QTY_RST;
      refresh_pattern <= PATTERN_RST;
      retry_count     <= RETRY_RST;
      monitor_time    <= MONITOR_RST;
      irq_stat        <= 8'h00;
      irq_mask        <= 8'h00;
      rdata           <= 16'h0000;
      irq             <= 1'b0;
      port_sel        <= 1'b0;
    end
    else
    begin
      station_number  <= next_station_number;
      slave_quantity  <= next_slave_quantity;
      refresh_pattern <= next_refresh_pattern;
      retry_count     <= next_retry_count;
      monitor_time    <= next_monitor_time;
      irq_stat        <= next_irq_stat;
      irq_mask        <= next_irq_mask;
      rdata           <= next_rdata;
      irq             <= next_irq;
      port_sel        <= ch_sync;
    end
  end

  // Shared memory writes; nothing ever clears it
  assign rx_data    = RX_VALID_I && RX_FRAME_I.kind == FRAME_DATA;
  assign mem_rx_we  = rx_data && RX_FRAME_I.station != own
                      && slot_live(act_pat, RX_FRAME_I.index);
  assign mem_bus_we = REG_WR_I && bus_slot.ok && bus_slot.station == own;

  always_ff @(posedge CLK_SYS_I)
  begin
    if (mem_rx_we)
      shared_mem[RX_FRAME_I.station][RX_FRAME_I.index] <= RX_FRAME_I.data;
    if (mem_bus_we)
      shared_mem[own][bus_slot.index] <= REG_WDATA_I;
  end

  // Link sequencer
  always_comb
  begin
    logic advance;
    advance        = 1'b0;
    give_up        = 1'b0;
    next_state     = state;
    next_target    = target;
    next_item      = item;
    next_attempt   = attempt;
    next_units     = units;
    next_watch     = watch;
    next_slave_pat = slave_pat;
    next_seq_err   = seq_err;
    next_running   = running;
    next_cyc_fault = cyc_fault;
    next_tx_valid  = tx_valid;
    next_tx_frame  = tx_frame;
    tick           = (prescale == 20'(UNIT_CYCLES - 1));
    next_prescale  = tick ? 20'h00000 : 20'(prescale + 20'h00001);
    if (!param_sync)
    begin
      next_state    = ST_IDLE;
      next_running  = 1'b0;
      next_tx_valid = 1'b0;
    end
    else
    begin
      unique case (state)
        ST_IDLE:
          if (is_master)
          begin
            next_target    = 3'h0;
            next_item      = 4'h0;
            next_cyc_fault = 1'b0;
            next_state     = ST_SEND;
          end
          else if (RX_VALID_I && RX_FRAME_I.kind == FRAME_POLL && RX_FRAME_I.station == own)
          begin
            next_slave_pat = RX_FRAME_I.data[1:0];
            next_item      = 4'h0;
            next_state     = ST_SEND;
          end
        ST_SEND:
          if (!tx_valid)
          begin
            next_tx_valid = 1'b1;
            next_tx_frame = {FRAME_DATA, own, slot_index(act_pat, item),
                             shared_mem[own][slot_index(act_pat, item)]};
          end
          else if (TX_READY_I)
          begin
            next_tx_valid = 1'b0;
            next_item     = 4'(item + 4'h1);
            if (item == 4'(total - 4'h1))
            begin
              advance    = is_master;
              next_state = is_master ? state : ST_IDLE;
            end
          end
        ST_POLL:
          if (!tx_valid)
          begin
            next_tx_valid = 1'b1;
            next_tx_frame = {FRAME_POLL, target, 4'h0, {14'h0000, act_pat}};
          end
          else if (TX_READY_I)
          begin
            next_tx_valid = 1'b0;
            next_units    = 8'h00;
            next_item     = 4'h0;
            next_state    = ST_WAIT;
          end
        ST_WAIT:
          if (rx_data && RX_FRAME_I.station == target)
          begin
            next_item = 4'(item + 4'h1);
            if (item == 4'(total - 4'h1))
            begin
              next_seq_err[target] = 1'b0;
              advance              = 1'b1;
            end
          end
          else if (rx_data)
          begin
            next_seq_err[0] = 1'b1;
            next_cyc_fault  = 1'b1;
          end
          else if (tick)
          begin
            next_units = 8'(units + 8'h01);
            if (16'(units + 8'h01) >= monitor_time)
            begin
              if (16'(attempt) < retry_count)
              begin
                next_attempt = 4'(attempt + 4'h1);
                next_state   = ST_POLL;
              end
              else
              begin
                give_up              = 1'b1;
                next_seq_err[target] = 1'b1;
                advance              = 1'b1;
              end
            end
          end
        default:
          next_state = ST_IDLE;
      endcase
      if (advance)
      begin
        next_attempt = 4'h0;
        next_item    = 4'h0;
        if (16'(target) >= slave_quantity)
        begin
          next_running    = 1'b1;
          next_seq_err[0] = cyc_fault;
          next_cyc_fault  = 1'b0;
          next_target     = 3'h0;
          next_state      = ST_SEND;
        end
        else
        begin
          next_target = 3'(target + 3'h1);
          next_state  = ST_POLL;
        end
      end
      if (!is_master)
      begin
        if (rx_data && RX_FRAME_I.station == 3'h0)
        begin
          next_watch      = 8'h00;
          next_seq_err[0] = 1'b0;
          next_running    = 1'b1;
        end
        else if (tick && watch >= 8'(SLAVE_WATCH - 8'h01))
        begin
          next_seq_err[0] = 1'b1;
          next_running    = 1'b0;
        end
        else if (tick)
          next_watch = 8'(watch + 8'h01);
      end
    end
  end

  always_ff @(posedge CLK_SYS_I or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state     <= ST_IDLE;
      target    <= 3'h0;
      item      <= 4'h0;
      attempt   <= 4'h0;
      units     <= 8'h00;
      watch     <= 8'h00;
      prescale  <= 20'h00000;
      slave_pat <= 2'h0;
      seq_err   <= 8'h00;
      running   <= 1'b0;
      cyc_fault <= 1'b0;
      tx_valid  <= 1'b0;
      tx_frame  <= '0;
    end
    else
    begin
      state     <= next_state;
      target    <= next_target;
      item      <= next_item;
      attempt   <= next_attempt;
      units     <= next_units;
      watch     <= next_watch;
      prescale  <= next_prescale;
      slave_pat <= next_slave_pat;
      seq_err   <= next_seq_err;
      running   <= next_running;
      cyc_fault <= next_cyc_fault;
      tx_valid  <= next_tx_valid;
      tx_frame  <= next_tx_frame;
    end
  end

  assign REG_RDATA_O = rdata;
  assign PORT_SEL_O  = port_sel;
  assign TX_VALID_O  = tx_valid;
  assign TX_FRAME_O  = tx_frame;
  assign SEQ_ERR_O   = seq_err;
  assign LINK_RUN_O  = running;
  assign IRQ_O       = irq;

  // Checks
  role_poll_a: assert property (@(posedge CLK_SYS_I) disable iff (!rst_n)
    (state == ST_POLL) |-> is_master)
    else $error("slave station issued a poll");
  poll_range_a: assert property (@(posedge CLK_SYS_I) disable iff (!rst_n)
    (state == ST_POLL) |-> (target >= 3'h1 && 16'(target) <= slave_quantity))
    else $error("poll target outside slave quantity");
  pattern_range_a: assert property (@(posedge CLK_SYS_I) disable iff (!rst_n)
    refresh_pattern <= PATTERN_MAX && slave_pat != 2'h3)
    else $error("refresh pattern out of range");
  retry_error_a: assert property (@(posedge CLK_SYS_I) disable iff (!rst_n)
    give_up |-> (16'(attempt) == retry_count) ##1 seq_err[$past(target)])
    else $error("slave error not raised after last retry");
  timeout_bound_a: assert property (@(posedge CLK_SYS_I) disable iff (!rst_n)
    (state == ST_WAIT) |-> 16'(units) < monitor_time)
    else $error("wait ran past monitoring time");
  slave_ignore_a: assert property (@(posedge CLK_SYS_I) disable iff (!rst_n)
    (!is_master && $changed(refresh_pattern)) |-> act_pat == slave_pat)
    else $error("slave pattern followed its own word");
  port_route_a: assert property (@(posedge CLK_SYS_I) disable iff (!rst_n)
    ch_sync ##1 ch_sync |-> PORT_SEL_O)
    else $error("port select does not follow channel select");
  run_stop_a: assert property (@(posedge CLK_SYS_I) disable iff (!rst_n)
    !param_sync |=> !LINK_RUN_O)
    else $error("link running without parameter flag");
  own_guard_a: assert property (@(posedge CLK_SYS_I) disable iff (!rst_n)
    mem_rx_we |-> RX_FRAME_I.station != own)
    else $error("received frame overwrote own area");
  irq_level_a: assert property (@(posedge CLK_SYS_I) disable iff (!rst_n)
    (|(irq_stat & irq_mask)) |-> IRQ_O)
    else $error("interrupt low while unmasked status set");

endmodule
`default_nettype wire

// ### testbench/mlk_far.sv
`timescale 1ns/10ps
`default_nettype none
module mlk_far
  import mlk_pkg::*;
(
  // Clock
  input  wire logic          clk_i,
  // From the station, and the per-station answer enables
  input  wire logic          tx_valid_i,
  input  wire mlk_frame_type tx_frame_i,
  input  wire logic [7:0]    answer_i,
  // To the station
  output logic               tx_ready_o = 1'b0,
  output logic               rx_valid_o = 1'b0,
  output mlk_frame_type      rx_frame_o = '0
);
  logic [3:0] left  = 4'h0;
  logic [3:0] words = 4'h0;
  logic [3:0] idx   = 4'h0;
  logic [2:0] who   = 3'h0;
  // Slow acceptance, idle lines scrambled
  always @(posedge clk_i)
  begin
    tx_ready_o <= ~tx_ready_o;
    rx_valid_o <= 1'b0;
    rx_frame_o <= ~rx_frame_o;
    if (tx_valid_i && tx_ready_o && tx_frame_i.kind == FRAME_POLL
        && answer_i[tx_frame_i.station])
    begin
      who   <= tx_frame_i.station;
      idx   <= 4'h0;
      words <= (tx_frame_i.data[1:0] == 2'h2) ? 4'h8 : 4'h4;
      left  <= (tx_frame_i.data[1:0] == 2'h0) ? 4'h4 :
               (tx_frame_i.data[1:0] == 2'h1) ? 4'h6 : 4'hC;
    end
    else if (left != 4'h0)
    begin
      rx_valid_o <= 1'b1;
      rx_frame_o <= {FRAME_DATA, who, idx, 8'hA0, 1'b0, who, idx};
      idx        <= (idx + 4'h1 == words) ? 4'h8 : idx + 4'h1;
      left       <= left - 4'h1;
    end
  end
endmodule
`default_nettype wire

// ### testbench/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module tb_top
  import mlk_pkg::*;
;
  logic          clk = 1'b0, rstn = 1'b0, wr = 1'b0, rd = 1'b0, rd_q = 1'b0;
  logic          prm = 1'b0, chs = 1'b0, psel, rxv, txr, txv, run, irq;
  logic [7:0]    addr = 8'h00, ans = 8'h02, err;
  logic [15:0]   wdata = 16'h0000, rdata, own, expq[$];
  logic [15:0]   rtab[5] = '{16'h0000, 16'h0007, 16'h0000, 16'h0003, 16'h0005};
  mlk_frame_type rxf, txf;
  logic [1:0]    pat;
  int            seed = 32'had566f6f;
  int            mismatches = 0;
  int            checked = 0;
  mlk_station #(.UNIT_CYCLES(20)) i_mlk_station (
    .CLK_SYS_I(clk), .RESETN_I(rstn), .REG_ADDR_I(addr), .REG_WDATA_I(wdata),
    .REG_WR_I(wr), .REG_RD_I(rd), .REG_RDATA_O(rdata), .PARAM_SET_I(prm),
    .CH_SELECT_I(chs), .PORT_SEL_O(psel), .RX_VALID_I(rxv), .RX_FRAME_I(rxf),
    .TX_READY_I(txr), .TX_VALID_O(txv), .TX_FRAME_O(txf), .SEQ_ERR_O(err),
    .LINK_RUN_O(run), .IRQ_O(irq));
  mlk_far i_mlk_far (.clk_i(clk), .tx_valid_i(txv), .tx_frame_i(txf),
    .answer_i(ans), .tx_ready_o(txr), .rx_valid_o(rxv), .rx_frame_o(rxf));
  task check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task close_out;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task bus(input logic w, input logic [7:0] a, input logic [15:0] d);
    addr <= a;
    wdata <= d;
    wr <= w;
    rd <= !w;
    @(posedge clk);
    wr <= 1'b0;
    rd <= 1'b0;
    @(posedge clk);
  endtask
  task rdx(input logic [7:0] a, input logic [15:0] e);
    expq.push_back(e);
    bus(1'b0, a, 16'h0000);
  endtask
  task wait_on(input logic [8:0] want);
    int n;
    n = 0;
    while (({run, err} & want) !== want)
    begin
      @(posedge clk);
      n++;
      if (n > 5000)
      begin
        mismatches++;
        close_out();
      end
    end
    @(posedge clk);
  endtask
  // Waits for a taken frame of this kind at slot 0 and checks its data
  task tx_seen(input mlk_kind_type k, input logic [15:0] d);
    int n;
    n = 0;
    while (!(txv && txr && txf.kind == k && txf.index == 4'h0))
    begin
      @(posedge clk);
      n++;
      if (n > 5000)
      begin
        mismatches++;
        close_out();
      end
    end
    check("tx data", txf.data, d);
    @(posedge clk);
  endtask
  // Read data checked in the cycle after the strobe
  always @(posedge clk)
    rd_q <= rd;
  always @(negedge clk)
    if (rd_q)
      check("read data", rdata, expq.pop_front());
  initial
  begin
    forever #50 clk = ~clk;
  end
  initial
  begin
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    repeat (3) @(posedge clk);
    for (int i = 0; i < 5; i++)
      rdx(8'(i), rtab[i]);
    bus(1'b1, ADDR_SLAVE_QTY, 16'h0002);
    rdx(ADDR_SLAVE_QTY, 16'h0007);
    prm <= 1'b1;
    repeat (3) @(posedge clk);
    bus(1'b1, ADDR_PATTERN, 16'h0003);
    bus(1'b1, ADDR_RETRY, 16'h000B);
    bus(1'b1, ADDR_MONITOR, 16'h0004);
    rdx(ADDR_PATTERN, 16'h0000);
    rdx(ADDR_RETRY, 16'h0003);
    rdx(ADDR_MONITOR, 16'h0005);
    pat = 2'($unsigned($random(seed)) % 3);
    own = 16'($random(seed));
    bus(1'b1, ADDR_PATTERN, {14'h0000, pat});
    bus(1'b1, ADDR_RETRY, 16'h0001);
    bus(1'b1, ADDR_SLAVE_QTY, 16'h0002);
    bus(1'b1, ADDR_IRQ_MASK, 16'h0004);
    bus(1'b1, WORD_AREA, own);
    bus(1'b1, WORD_AREA + WORD_STRIDE, 16'hFFFF);
    bus(1'b1, 8'h3F, 16'hFFFF);
    rdx(8'h3F, 16'h0000);
    rdx(ADDR_PATTERN, {14'h0000, pat});
    rdx(WORD_AREA, own);
    wait_on(9'h104);
    check("seq err", {8'h00, err}, 16'h0004);
    check("irq", {15'h0000, irq}, 16'h0001);
    tx_seen(FRAME_DATA, own);
    tx_seen(FRAME_POLL, {14'h0000, pat});
    rdx(ADDR_STATUS, 16'h0304);
    rdx(WORD_AREA + WORD_STRIDE, 16'hA010);
    rdx(ADDR_IRQ_STAT, 16'h0004);
    bus(1'b1, ADDR_IRQ_STAT, 16'h0004);
    rdx(ADDR_IRQ_STAT, 16'h0000);
    check("irq", {15'h0000, irq}, 16'h0000);
    ans <= 8'h00;
    wait_on(9'h006);
    rdx(WORD_AREA + WORD_STRIDE, 16'hA010);
    check("irq", {15'h0000, irq}, 16'h0000);
    chs <= 1'b1;
    prm <= 1'b0;
    repeat (5) @(posedge clk);
    check("port", {15'h0000, psel}, 16'h0001);
    check("run", {15'h0000, run}, 16'h0000);
    close_out();
  end
endmodule
`default_nettype wire
